// >>> rtl/io_port_map_and_test_select.sv
// Function
// - eight pin map registers at 0Fh to 16h
// - direction bit set means pin is input
// - low five bits pick the routed bit
// - write is address strobe then data strobe
// - four-bit test function register at 55h
// - reading test register restores all enables
// - scrambler runs only while its bit set
// - NRZI conversion only while its bit set
// - LSB clipping only while its bit set
// - sync detector only while its bit set
// - pattern word: format, scan, pattern kind
// - HD bits 4:2 pick the raster
// - power-on map puts lock detect on pin 4
// - input pin overrides the host-written bit
`default_nettype none
module io_port_map_and_test_select
	import io_map_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 sys_rst,
	input  wire logic                 aclk_pin,
	input  wire logic                 aux_or_control_select,
	input  wire logic                 rd_wr_sel,
	input  wire logic [AD_W-1:0]      ad_in,
	output logic      [AD_W-1:0]      ad_out,
	output logic                      ad_oe,
	input  wire logic [NUM_PINS-1:0]  io_in,
	output logic      [NUM_PINS-1:0]  io_out,
	output logic      [NUM_PINS-1:0]  io_oe,
	input  wire logic [NUM_FUNCS-1:0] mapped_bits,
	output logic      [NUM_FUNCS-1:0] force_valid,
	output logic      [NUM_FUNCS-1:0] force_value,
	output logic                      scrambler_en,
	output logic                      nrzi_en,
	output logic                      lsb_clip_en,
	output logic                      sync_detect_en,
	input  wire logic [5:0]           pattern_select,
	output pattern_decode_t           pattern_decode
);

	// ------------------------------------------------------------
	// pin-side synchronisers
	// ------------------------------------------------------------

	port_pins_t            pins_raw;   // port pins as sampled
	port_pins_t            pins_f;     // port pins after the filter
	logic [NUM_PINS-1:0]   io_sync;    // io port levels after the filter

	assign pins_raw = {aclk_pin, aux_or_control_select, rd_wr_sel, ad_in};

	// strobe, selects and bus share one chain so they stay aligned
	sync3_filter #(
		.W ($bits(port_pins_t))
	) u_port_sync (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.async_in (pins_raw),
		.level_q  (pins_f)
	);

	// io port pins arrive from the board, unrelated to clk_sys
	sync3_filter #(
		.W (NUM_PINS)
	) u_io_sync (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.async_in (io_in),
		.level_q  (io_sync)
	);

	// ------------------------------------------------------------
	// strobe edge and two-phase access sequence
	// ------------------------------------------------------------

	logic                  aclk_prev_q; // filtered strobe, one cycle old
	logic                  strobe;      // one pulse per rising strobe
	phase_t                phase_q;     // address or data phase
	logic [AD_W-1:0]       addr_q;      // address taken on first strobe
	logic                  rd_q;        // access kind taken with it

	// previous strobe level for edge detection
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			aclk_prev_q <= 1'b0;
		end else begin
			aclk_prev_q <= pins_f.aclk;
		end
	end

	assign strobe = pins_f.aclk & ~aclk_prev_q;

	// phase toggles on each control strobe; ancillary strobes
	// resynchronise so a stray one cannot leave us mid-access
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			phase_q <= PH_ADDR;
		end else if (strobe) begin
			if (pins_f.aux_sel) begin
				phase_q <= PH_ADDR;
			end else begin
				unique case (phase_q)
					PH_ADDR: phase_q <= PH_DATA;
					PH_DATA: phase_q <= PH_ADDR;
				endcase
			end
		end
	end

	// address and direction held from the first strobe
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			addr_q <= '0;
			rd_q   <= 1'b0;
		end else if (strobe && phase_q == PH_ADDR && !pins_f.aux_sel) begin
			addr_q <= pins_f.ad;
			rd_q   <= pins_f.rd_sel;
		end
	end

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------

	logic                  wr_en;       // data strobe of a control write
	logic                  rd_addr_ev;  // address strobe of a read
	logic                  map_hit;     // held address hits a map register
	logic [2:0]            map_idx;     // which map register
	logic                  test_hit;    // held address hits test register
	logic                  rd_test_hit; // read address names test register
	logic [AD_W-1:0]       map_off;     // offset into the map block

	// writes count only with control selected and write held low
	assign wr_en = strobe && phase_q == PH_DATA && !pins_f.aux_sel && !rd_q;
	assign rd_addr_ev = strobe && phase_q == PH_ADDR && !pins_f.aux_sel
		&& pins_f.rd_sel;

	assign map_hit = addr_q >= ADDR_PIN_MAP_BASE && addr_q <= ADDR_PIN_MAP_LAST;
	assign map_off = addr_q - ADDR_PIN_MAP_BASE;
	assign map_idx = map_off[2:0];
	assign test_hit = addr_q == ADDR_TEST_FUNC;
	assign rd_test_hit = pins_f.ad == ADDR_TEST_FUNC;

	// ------------------------------------------------------------
	// pin map registers and per-pin routing
	// ------------------------------------------------------------

	pin_map_t              map_q [NUM_PINS];     // map register per pin
	logic [NUM_PINS-1:0]   drv_val;              // selected bit per pin
	logic [NUM_FUNCS-1:0]  claim [NUM_PINS];     // bits claimed by inputs
	logic [NUM_FUNCS-1:0]  claim_val [NUM_PINS]; // levels they carry
	logic [NUM_PINS-1:0]   io_out_q;             // registered pin drive

	for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
		// map register: power-on default, then host writes
		always_ff @(posedge clk_sys) begin
			if (sys_rst) begin
				map_q[g] <= PIN_MAP_RST[g*MAP_W +: MAP_W];
			end else if (wr_en && map_hit && map_idx == 3'(g)) begin
				map_q[g] <= pins_f.ad[MAP_W-1:0];
			end
		end

		// direction and function decode for this pin
		pin_map_slice u_slice (
			.map       (map_q[g]),
			.pin_level (io_sync[g]),
			.reg_bits  (mapped_bits),
			.drive_val (drv_val[g]),
			.drive_en  (io_oe[g]),
			.claim     (claim[g]),
			.claim_val (claim_val[g])
		);
	end

	// output pins track their bit every cycle; a wrong-way mapping
	// is not trapped here, the host must not make one
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			io_out_q <= '0;
		end else begin
			io_out_q <= drv_val;
		end
	end

	assign io_out = io_out_q;

	// ------------------------------------------------------------
	// input pin overrides
	// ------------------------------------------------------------

	logic [NUM_FUNCS-1:0]  force_valid_d; // union of input claims
	logic [NUM_FUNCS-1:0]  force_value_d; // wired-or of their levels
	logic [NUM_FUNCS-1:0]  force_valid_q;
	logic [NUM_FUNCS-1:0]  force_value_q;

	// two inputs on one bit simply or together
	always_comb begin
		force_valid_d = '0;
		force_value_d = '0;
		for (int i = 0; i < NUM_PINS; i++) begin
			force_valid_d = force_valid_d | claim[i];
			force_value_d = force_value_d | claim_val[i];
		end
	end

	// the owner of each bit must let force_value win while valid,
	// so a pulled-down pin beats any host write to that bit
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			force_valid_q <= '0;
			force_value_q <= '0;
		end else begin
			force_valid_q <= force_valid_d;
			force_value_q <= force_value_d;
		end
	end

	assign force_valid = force_valid_q;
	assign force_value = force_value_q;

	// ------------------------------------------------------------
	// test function enables
	// ------------------------------------------------------------

	logic [TEST_W-1:0]     test_q; // scrambler, nrzi, clip, sync detect

	// a read restores all enables; read and write never share a strobe
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			test_q <= TEST_FUNC_RST;
		end else if (rd_addr_ev && rd_test_hit) begin
			test_q <= TEST_FUNC_RST;
		end else if (wr_en && test_hit) begin
			test_q <= pins_f.ad[TEST_W-1:0];
		end
	end

	assign scrambler_en   = test_q[TEST_BIT_SCRAMBLE];
	assign nrzi_en        = test_q[TEST_BIT_NRZI];
	assign lsb_clip_en    = test_q[TEST_BIT_LSB_CLIP];
	assign sync_detect_en = test_q[TEST_BIT_SYNC_DET];

	// ------------------------------------------------------------
	// read-back path
	// ------------------------------------------------------------

	logic [AD_W-1:0]       rd_word;  // value for the address on the bus
	logic [AD_W-1:0]       map_roff; // read offset into the map block
	logic [AD_W-1:0]       ad_out_q;
	logic                  ad_oe_q;

	assign map_roff = pins_f.ad - ADDR_PIN_MAP_BASE;

	// unmapped addresses read as zero
	always_comb begin
		rd_word = '0;
		if (pins_f.ad >= ADDR_PIN_MAP_BASE && pins_f.ad <= ADDR_PIN_MAP_LAST) begin
			rd_word[MAP_W-1:0] = map_q[map_roff[2:0]];
		end else if (rd_test_hit) begin
			rd_word[TEST_W-1:0] = test_q;
		end
	end

	// read data is the value before any read side effect
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ad_out_q <= '0;
		end else if (rd_addr_ev) begin
			ad_out_q <= rd_word;
		end
	end

	// bus driven from the address strobe until the next strobe
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ad_oe_q <= 1'b0;
		end else if (rd_addr_ev) begin
			ad_oe_q <= 1'b1;
		end else if (strobe) begin
			ad_oe_q <= 1'b0;
		end
	end

	assign ad_out = ad_out_q;
	assign ad_oe  = ad_oe_q;

	// ------------------------------------------------------------
	// test pattern select word decode
	// ------------------------------------------------------------

	// one HD progressive code is not listed and reads back invalid
	function automatic pattern_decode_t decode_pattern(input logic [5:0] s);
		pattern_decode_t d;
		d.valid       = 1'b1;
		d.hd          = s[5];
		d.prog_or_pal = s[4];
		d.sd_variant  = s[3:2];
		d.kind        = pattern_kind_t'(s[1:0]);
		d.raster      = RAS_NONE;
		if (s[5]) begin
			unique case (s[4:2])
				3'b000: d.raster = RAS_HD_I30_260M;
				3'b001: d.raster = RAS_HD_I30_274M;
				3'b010: d.raster = RAS_HD_I25_274M;
				3'b011: d.raster = RAS_HD_I25_295M;
				3'b100: d.raster = RAS_HD_P30;
				3'b101: d.valid  = 1'b0;
				3'b110: d.raster = RAS_HD_P24;
				3'b111: d.raster = RAS_HD_P60_750;
			endcase
		end else begin
			d.raster = s[4] ? RAS_SD_PAL : RAS_SD_NTSC;
			d.valid  = s[3:2] != 2'b11;
		end
		return d;
	endfunction

	pattern_decode_t       pattern_q; // registered decode

	// decode registered so consumers see a clean word
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pattern_q <= '0;
		end else begin
			pattern_q <= decode_pattern(pattern_select);
		end
	end

	assign pattern_decode = pattern_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------

	property p_map_write;
		@(posedge clk_sys) disable iff (sys_rst)
		wr_en && map_hit |=> map_q[$past(map_idx)] == $past(pins_f.ad[5:0]);
	endproperty
	a_map_write: assert property (p_map_write)
		else $error("map register missed its write");

	property p_dir;
		@(posedge clk_sys) disable iff (sys_rst)
		wr_en && map_hit |=> io_oe[$past(map_idx)] == !$past(pins_f.ad[5]);
	endproperty
	a_dir: assert property (p_dir)
		else $error("pin direction does not follow its select bit");

	property p_two_strobe;
		@(posedge clk_sys) disable iff (sys_rst)
		strobe && phase_q == PH_ADDR && !rd_addr_ev
			|=> $stable(test_q) && map_q[0] == $past(map_q[0]);
	endproperty
	a_two_strobe: assert property (p_two_strobe)
		else $error("register changed on an address strobe");

	property p_read_default;
		@(posedge clk_sys) disable iff (sys_rst)
		rd_addr_ev && rd_test_hit |=> test_q == TEST_FUNC_RST ##1 ad_oe;
	endproperty
	a_read_default: assert property (p_read_default)
		else $error("test register read did not restore enables");

	property p_scramble;
		@(posedge clk_sys) disable iff (sys_rst)
		wr_en && test_hit && !pins_f.ad[0] |=> !scrambler_en;
	endproperty
	a_scramble: assert property (p_scramble)
		else $error("scrambler still enabled after clear");

	property p_sync_det;
		@(posedge clk_sys) disable iff (sys_rst)
		wr_en && test_hit && pins_f.ad[3] |=> sync_detect_en [*1]
			##0 lsb_clip_en == $past(pins_f.ad[2]);
	endproperty
	a_sync_det: assert property (p_sync_det)
		else $error("sync detect or clip enable wrong after write");

	property p_reset_map;
		@(posedge clk_sys) disable iff (sys_rst)
		$fell(sys_rst) |-> map_q[4].func == FUNC_LOCK && !map_q[4].is_input && io_oe[4];
	endproperty
	a_reset_map: assert property (p_reset_map)
		else $error("lock detect not on pin 4 after reset");

	property p_override;
		@(posedge clk_sys) disable iff (sys_rst)
		map_q[7].is_input && $stable(map_q[7]) |=> force_valid[$past(map_q[7].func)]
			&& (force_value[$past(map_q[7].func)] || !$past(io_sync[7]));
	endproperty
	a_override: assert property (p_override)
		else $error("input pin does not override its bit");

	property p_follow;
		@(posedge clk_sys) disable iff (sys_rst)
		!map_q[0].is_input |=> io_out[0] == $past(mapped_bits[map_q[0].func]);
	endproperty
	a_follow: assert property (p_follow)
		else $error("output pin 0 does not follow its bit");

endmodule
`default_nettype wire

// >>> rtl/io_map_pkg.sv
`default_nettype none
package io_map_pkg;

	// geometry of the pin map and the control port
	localparam int NUM_PINS    = 8;
	localparam int FUNC_W      = 5;
	localparam int MAP_W       = 6;
	localparam int MAP_DIR_BIT = 5;
	localparam int AD_W        = 10;
	localparam int NUM_FUNCS   = 32;

	// register addresses on the ten-bit address/data bus
	localparam logic [AD_W-1:0] ADDR_PIN_MAP_BASE = 10'h00F;
	localparam logic [AD_W-1:0] ADDR_PIN_MAP_LAST = 10'h016;
	localparam logic [AD_W-1:0] ADDR_TEST_FUNC    = 10'h055;

	// test function enable bits and their value after reset or read
	localparam int TEST_W             = 4;
	localparam int TEST_BIT_SCRAMBLE  = 0;
	localparam int TEST_BIT_NRZI      = 1;
	localparam int TEST_BIT_LSB_CLIP  = 2;
	localparam int TEST_BIT_SYNC_DET  = 3;
	localparam logic [TEST_W-1:0] TEST_FUNC_RST = 4'hF;

	// function codes used by the power-on pin map
	localparam logic [FUNC_W-1:0] FUNC_CRC_ERR  = 5'h04;
	localparam logic [FUNC_W-1:0] FUNC_TPG_EN   = 5'h08;
	localparam logic [FUNC_W-1:0] FUNC_FIELD    = 5'h12;
	localparam logic [FUNC_W-1:0] FUNC_VBLANK   = 5'h13;
	localparam logic [FUNC_W-1:0] FUNC_HBLANK   = 5'h14;
	localparam logic [FUNC_W-1:0] FUNC_FMT4     = 5'h19;
	localparam logic [FUNC_W-1:0] FUNC_LOCK     = 5'h1C;
	localparam logic [FUNC_W-1:0] FUNC_PASSFAIL = 5'h1D;

	// power-on map, pin 7 in the top field down to pin 0
	localparam logic [NUM_PINS*MAP_W-1:0] PIN_MAP_RST = {
		{1'b1, FUNC_TPG_EN}, {1'b0, FUNC_PASSFAIL}, {1'b0, FUNC_CRC_ERR},
		{1'b0, FUNC_LOCK}, {1'b0, FUNC_FMT4}, {1'b0, FUNC_HBLANK},
		{1'b0, FUNC_VBLANK}, {1'b0, FUNC_FIELD}};

	typedef struct packed {
		logic              is_input; // direction: 1 = pin is an input
		logic [FUNC_W-1:0] func;     // register bit routed to or from the pin
	} pin_map_t;

	typedef struct packed {
		logic            aclk;    // port strobe
		logic            aux_sel; // high = ancillary, low = control access
		logic            rd_sel;  // high = read, low = write
		logic [AD_W-1:0] ad;      // address/data bus
	} port_pins_t;

	typedef enum logic {
		PH_ADDR = 1'b0,
		PH_DATA = 1'b1
	} phase_t;

	typedef enum logic [1:0] {
		PAT_BLACK = 2'b00,
		PAT_PLL   = 2'b01,
		PAT_EQ    = 2'b10,
		PAT_BARS  = 2'b11
	} pattern_kind_t;

	typedef enum logic [3:0] {
		RAS_HD_I30_260M = 4'b0000,
		RAS_HD_I30_274M = 4'b0001,
		RAS_HD_I25_274M = 4'b0010,
		RAS_HD_I25_295M = 4'b0011,
		RAS_HD_P30      = 4'b0100,
		RAS_HD_P24      = 4'b0101,
		RAS_HD_P60_750  = 4'b0110,
		RAS_SD_NTSC     = 4'b0111,
		RAS_SD_PAL      = 4'b1000,
		RAS_NONE        = 4'b1111
	} raster_t;

	typedef struct packed {
		logic          valid;       // code names a listed pattern
		logic          hd;          // 1 = HD, 0 = SD
		logic          prog_or_pal; // HD: progressive, SD: PAL
		logic [1:0]    sd_variant;  // SD raster variant bits
		raster_t       raster;
		pattern_kind_t kind;
	} pattern_decode_t;

endpackage
`default_nettype wire

// >>> rtl/sync3_filter.sv
`default_nettype none
module sync3_filter #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] level_q
);

	logic [W-1:0] s1_q; // first stage, read only by the second
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// three-flop chain per bit
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a bit moves only once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			level_q <= '0;
		end else begin
			level_q <= (s2_q & s3_q) | (level_q & (s2_q ^ s3_q));
		end
	end

endmodule
`default_nettype wire

// >>> rtl/pin_map_slice.sv
`default_nettype none
module pin_map_slice
	import io_map_pkg::*;
(
	input  wire pin_map_t             map,
	input  wire logic                 pin_level,
	input  wire logic [NUM_FUNCS-1:0] reg_bits,
	output logic                      drive_val,
	output logic                      drive_en,
	output logic      [NUM_FUNCS-1:0] claim,
	output logic      [NUM_FUNCS-1:0] claim_val
);

	// output pin carries the selected bit, input pin claims it
	always_comb begin
		drive_en  = ~map.is_input;
		drive_val = reg_bits[map.func];
		claim     = '0;
		if (map.is_input) begin
			claim[map.func] = 1'b1;
		end
		claim_val = claim & {NUM_FUNCS{pin_level}};
	end

endmodule
`default_nettype wire

// >>> verif/host_port_model.sv
`default_nettype none
module host_port_model
	import io_map_pkg::*;
(
	input  wire logic            clk_sys,
	output logic                 aclk_pin,
	output logic                 aux_sel,
	output logic                 rd_wr_sel,
	output logic      [AD_W-1:0] ad_drv
);
	timeunit 1ns;
	timeprecision 1ps;

	int hold_clk = 8; // cycles per strobe half, raised to act as a slow host

	// idle levels; strobe low so the synchronisers see no edge at release
	initial begin
		aclk_pin  = 1'b0;
		aux_sel   = 1'b0;
		rd_wr_sel = 1'b0;
		ad_drv    = 10'h3FF;
	end

	// one strobe, bus and selects held across both halves
	task automatic strobe();
		repeat (hold_clk) @(negedge clk_sys);
		aclk_pin = 1'b1;
		repeat (hold_clk) @(negedge clk_sys);
		aclk_pin = 1'b0;
	endtask

	// address strobe then data strobe; selects low picks a control write
	task automatic cycle(input logic aux, input logic rd, input logic [AD_W-1:0] addr,
			input logic [AD_W-1:0] data);
		aux_sel   = aux;
		rd_wr_sel = rd;
		ad_drv    = addr;
		strobe();
		ad_drv = data;
		strobe();
		repeat (hold_clk) @(negedge clk_sys);
		// released bus: show the inverse, never the stale word
		ad_drv    = ~data;
		aux_sel   = 1'b0;
		rd_wr_sel = 1'b0;
		// let an edge pass so the next transfer never reassigns in this step
		@(negedge clk_sys);
	endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`default_nettype none
module testbench
	import io_map_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 clk_sys;        // system clock
	logic                 sys_rst;        // synchronous reset
	logic                 aclk_pin;       // host strobe
	logic                 aux_sel;        // host ancillary select
	logic                 rd_wr_sel;      // host read select
	logic [AD_W-1:0]      host_ad;        // what the host drives
	logic [AD_W-1:0]      ad_in;          // resolved bus level
	logic [AD_W-1:0]      ad_out;         // device read data
	logic                 ad_oe;          // device drives the bus
	logic [NUM_PINS-1:0]  ext_lvl;        // far-side pin levels
	logic [NUM_PINS-1:0]  io_in;          // resolved pin levels
	logic [NUM_PINS-1:0]  io_out;         // pin drive values
	logic [NUM_PINS-1:0]  io_oe;          // pin drive enables
	logic [NUM_FUNCS-1:0] mapped_bits;    // routable register bits
	logic [NUM_FUNCS-1:0] force_valid;    // input-pin claims
	logic [NUM_FUNCS-1:0] force_value;    // input-pin values
	logic                 scrambler_en;   // test enable 0
	logic                 nrzi_en;        // test enable 1
	logic                 lsb_clip_en;    // test enable 2
	logic                 sync_detect_en; // test enable 3
	logic [5:0]           pattern_select; // pattern word
	pattern_decode_t      pattern_decode; // decoded pattern
	logic                 oe_seen;        // ad_oe one cycle back
	logic [31:0]          lfsr_q;         // random source
	logic [31:0]          enables;        // test enables, zero-extended
	logic [AD_W-1:0]      rd_q[$];        // expected read words, oldest first
	int                   failures;
	int                   compares;

	// whoever enables wins the wire; undriven pins take the far-side level
	assign ad_in = ad_oe ? ad_out : host_ad;
	assign io_in = (io_oe & io_out) | (~io_oe & ext_lvl);
	assign enables = {28'h0, sync_detect_en, lsb_clip_en, nrzi_en, scrambler_en};

	host_port_model host (
		.clk_sys   (clk_sys),
		.aclk_pin  (aclk_pin),
		.aux_sel   (aux_sel),
		.rd_wr_sel (rd_wr_sel),
		.ad_drv    (host_ad)
	);

	io_port_map_and_test_select uut (
		.clk_sys               (clk_sys),
		.sys_rst               (sys_rst),
		.aclk_pin              (aclk_pin),
		.aux_or_control_select (aux_sel),
		.rd_wr_sel             (rd_wr_sel),
		.ad_in                 (ad_in),
		.ad_out                (ad_out),
		.ad_oe                 (ad_oe),
		.io_in                 (io_in),
		.io_out                (io_out),
		.io_oe                 (io_oe),
		.mapped_bits           (mapped_bits),
		.force_valid           (force_valid),
		.force_value           (force_value),
		.scrambler_en          (scrambler_en),
		.nrzi_en               (nrzi_en),
		.lsb_clip_en           (lsb_clip_en),
		.sync_detect_en        (sync_detect_en),
		.pattern_select        (pattern_select),
		.pattern_decode        (pattern_decode)
	);

	// 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// closing verdict, the single end of the run
	task automatic report_and_stop();
		if (failures == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// note the expected word, then run the read through the host
	task automatic rd_check(input logic [AD_W-1:0] addr, input logic [AD_W-1:0] exp);
		rd_q.push_back(exp);
		host.cycle(1'b0, 1'b1, addr, ~addr);
	endtask

	// random routed bits must show on the pin one cycle later
	task automatic out_check(input int pin, input logic [FUNC_W-1:0] code);
		logic [NUM_FUNCS-1:0] v; // next stimulus word
		repeat (4) begin
			lfsr_q = lfsr_next(lfsr_q);
			// early lfsr steps leave the high bits at zero, so force a toggle
			v = lfsr_q;
			v[code] = ~mapped_bits[code];
			mapped_bits = v;
			@(negedge clk_sys);
			check_val("io_out", 32'(mapped_bits[code]), 32'(io_out[pin]));
		end
	endtask

	// field mask hides what the decoder leaves open on unlisted codes
	task automatic check_pat(input logic [5:0] s);
		pattern_decode_t e;
		logic [10:0] m;
		e = '0;
		e.valid = 1'b1;
		e.hd = s[5];
		e.prog_or_pal = s[4];
		e.sd_variant = s[3:2];
		e.kind = pattern_kind_t'(s[1:0]);
		if (!s[5]) begin
			e.raster = s[4] ? RAS_SD_PAL : RAS_SD_NTSC;
			e.valid = (s[3:2] != 2'b11);
		end else if (!s[4]) begin
			e.raster = raster_t'({2'b00, s[3:2]});
		end else begin
			case (s[3:2])
				2'b00: e.raster = RAS_HD_P30;
				2'b10: e.raster = RAS_HD_P24;
				2'b11: e.raster = RAS_HD_P60_750;
				default: e.valid = 1'b0;
			endcase
		end
		m = !e.valid ? 11'h400 : (s[5] ? 11'h73F : 11'h7FF);
		check_val("pattern", 32'(e & m), 32'(pattern_decode & m));
	endtask

	// read watcher: a rising ad_oe takes the oldest note
	always @(posedge clk_sys) begin
		if (ad_oe === 1'b1 && oe_seen !== 1'b1) begin
			if (rd_q.size() == 0) begin
				check_val("stray read", 32'h0, 32'h1);
			end else begin
				check_val("read", 32'(rd_q.pop_front()), 32'(ad_out));
			end
		end
		oe_seen <= ad_oe;
	end

	// hang guard, well beyond the roughly 1550 cycles the tests take
	initial begin
		repeat (30000) @(posedge clk_sys);
		failures++;
		report_and_stop();
	end

	initial begin
		failures = 0;
		compares = 0;
		lfsr_q = 32'h0000001C;
		sys_rst = 1'b1;
		ext_lvl = 8'h00;
		mapped_bits = '0;
		pattern_select = 6'h00;
		repeat (10) @(negedge clk_sys);
		sys_rst = 1'b0;
		@(negedge clk_sys);
		check_val("io_oe", 32'h7F, 32'(io_oe));
		check_val("enables", 32'hF, enables);
		for (int i = 0; i < NUM_PINS; i++) begin
			rd_check(ADDR_PIN_MAP_BASE + 10'(i),
				(i == 4) ? {5'h00, FUNC_LOCK} : {4'h0, PIN_MAP_RST[i*MAP_W +: MAP_W]});
		end
		out_check(4, FUNC_LOCK);
		// upper data bits are dropped on write
		host.cycle(1'b0, 1'b0, ADDR_PIN_MAP_BASE, 10'h310);
		rd_check(ADDR_PIN_MAP_BASE, 10'h010);
		out_check(0, 5'h10);
		// pin 1 as input on the same input function as pin 7
		host.cycle(1'b0, 1'b0, ADDR_PIN_MAP_BASE + 10'h001, 10'h028);
		check_val("io_oe", 32'h7D, 32'(io_oe));
		ext_lvl = 8'h02;
		repeat (8) @(negedge clk_sys);
		check_val("force_valid", 32'h100, force_valid);
		check_val("force_value", 32'h100, force_value);
		ext_lvl = 8'h00;
		repeat (8) @(negedge clk_sys);
		check_val("force_value", 32'h0, force_value);
		// every enable combination
		for (int v = 0; v < 16; v++) begin
			host.cycle(1'b0, 1'b0, ADDR_TEST_FUNC, 10'(v));
			check_val("enables", 32'(v), enables);
		end
		host.cycle(1'b0, 1'b0, ADDR_TEST_FUNC, 10'h005);
		rd_check(ADDR_TEST_FUNC, 10'h005);
		check_val("enables", 32'hF, enables);
		rd_check(ADDR_TEST_FUNC, 10'h00F);
		// unmapped place reads zero; slow ancillary strobes change nothing
		host.cycle(1'b0, 1'b0, 10'h030, 10'h2A5);
		rd_check(10'h030, 10'h000);
		host.hold_clk = 14;
		host.cycle(1'b1, 1'b0, ADDR_PIN_MAP_BASE, 10'h3FF);
		host.hold_clk = 8;
		rd_check(ADDR_PIN_MAP_BASE, 10'h010);
		for (int s = 0; s < 64; s++) begin
			pattern_select = 6'(s);
			@(negedge clk_sys);
			check_pat(pattern_select);
		end
		// second reset restores the power-on directions
		sys_rst = 1'b1;
		repeat (4) @(negedge clk_sys);
		sys_rst = 1'b0;
		@(negedge clk_sys);
		check_val("io_oe", 32'h7F, 32'(io_oe));
		repeat (20) @(negedge clk_sys);
		check_val("reads left", 32'h0, 32'(rd_q.size()));
		report_and_stop();
	end
endmodule
`default_nettype wire
